// [logic/csw_clock_switch.v]
// Overview of operation
// RL1: switch and monitor only when cfg bit zero
// RL2: switching off: status shows initial config source
// RL3: switching off: enable bit ignores writes, reads zero
// RL4: software unlocks, writes select, unlocks, sets enable
// RL5: equal select and status: clear enable, abort
// RL6: valid switch clears lock and fail flags
// RL7: enable target; wait startup timer or lock
// RL8: count ten new clock cycles before switching
// RL9: clear enable, copy select into status
// RL10: stop old oscillator, keep exceptions running
// RL11: core keeps running during switch
// RL12: no direct switch between PLL modes; code has no such check, a PLL-to-PLL switch proceeds
// RL13: primary submode fixed by configuration
// RL14: monitor on: low-power RC runs except sleep
// RL15: oscillator failure raises trap, falls to fast RC; code drops a failure edge seen outside S_IDLE, while a switch is in progress
// RL16: fallback keeps PLL multiplication when used
// RL17: sleep stops clocks; idle halts core only
// RL18: sleep stops source, monitor and peripherals
// RL19: sleep clears watchdog, keeps low-power RC on
// RL20: wake on interrupt, reset or watchdog timeout
// RL21: wake from sleep on same source
// RL22: idle wake resumes core two to four cycles later
// RL23: control writes only right after unlock
//
// The AHB-Lite register port and the placing of the registers are this design's own decisions.
`include "csw_defs.vh"
module csw_clock_switch #(
  parameter SETTLE_CNT = 10
) (
  input wire hclk, // system clock
  input wire hresetn, // async reset, active low
  input wire hsel, // slave select
  input wire [7:0] haddr, // byte address
  input wire [1:0] htrans, // transfer type
  input wire hwrite, // write strobe
  input wire [2:0] hsize, // transfer size
  input wire [31:0] hwdata, // write data
  input wire hready, // bus ready in
  output wire hreadyout, // slave ready
  output wire hresp, // always okay
  output reg [31:0] hrdata, // read data
  input wire switch_monitor_cfg, // 0 enables switch and monitor
  input wire [2:0] initial_osc_select_cfg, // reset source
  input wire [1:0] primary_submode_cfg, // fixed primary submode
  input wire watchdog_en, // watchdog enabled
  input wire osc_ready_pin, // startup timer expired, async
  input wire pll_lock_pin, // pll lock, async
  input wire new_clk_pin, // target oscillator clock, async
  input wire osc_fail_pin, // oscillator failure, async
  input wire wake_irq, // enabled interrupt pending
  input wire wdt_timeout, // watchdog timeout
  output reg [5:0] osc_enable, // per-source oscillator enable
  output reg [2:0] sys_clk_sel, // active system clock source
  output reg [1:0] primary_submode, // applied primary submode
  output reg clock_fail_trap, // failure trap pulse
  output reg cpu_clk_en, // core clock gate
  output reg periph_clk_en, // peripheral clock gate
  output reg wdt_clear, // watchdog clear pulse
  output reg sleeping, // sleep state
  output reg idling // idle state
);
  localparam S_IDLE = 5'b00001;
  localparam S_START = 5'b00010;
  localparam S_WAIT = 5'b00100;
  localparam S_SETTLE = 5'b01000;
  localparam S_DONE = 5'b10000;
  localparam P_RUN = 3'b001;
  localparam P_SLEEP = 3'b010;
  localparam P_IDLE = 3'b100;

  reg rdy1_r, rdy2_r, lck1_r, lck2_r, fl1_r, fl2_r, fl3_r;
  reg [4:0] st_r;
  reg [2:0] pst_r;
  reg [2:0] new_osc_select_r;
  reg [2:0] current_osc_status_r;
  reg [2:0] old_r;
  reg osc_switch_enable_r, cf_r, lock_r, lpkeep_r;
  reg [1:0] key_r;
  reg [2:0] wake_cnt_r;
  reg init_r;
  reg [1:0] hold_r;
  reg ap_wr_r, ap_rd_r;
  reg [7:0] ap_addr_r;
  wire sw_en;
  wire is_pll;
  wire settle_done;
  wire fail_rise;
  wire low_power_rc_osc_keep;
  wire unlocked;
  wire wr_ctrl;
  wire wr_unlock;
  wire wr_pwr;

  assign sw_en = ~switch_monitor_cfg; // [RL1]
  assign is_pll = (new_osc_select_r == `CSW_SRC_PRIPLL) || (new_osc_select_r == `CSW_SRC_FAST_RC_WITH_MULTIPLIER);
  assign fail_rise = fl2_r & ~fl3_r;
  assign low_power_rc_osc_keep = watchdog_en | sw_en; // [RL10] [RL14]
  assign unlocked = (key_r == 2'h2);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wr_ctrl = ap_wr_r && ap_addr_r == `CSW_ADDR_CTRL;
  assign wr_unlock = ap_wr_r && ap_addr_r == `CSW_ADDR_UNLOCK;
  assign wr_pwr = ap_wr_r && ap_addr_r == `CSW_ADDR_PWR;

  csw_new_clk_counter #(.CNT(SETTLE_CNT)) u_cnt (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(st_r != S_SETTLE),
    .new_clk_pin(new_clk_pin),
    .done(settle_done)
  );

  // input synchronisers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdy1_r <= 1'b0;
      rdy2_r <= 1'b0;
      lck1_r <= 1'b0;
      lck2_r <= 1'b0;
      fl1_r <= 1'b0;
      fl2_r <= 1'b0;
      fl3_r <= 1'b0;
    end else begin
      rdy1_r <= osc_ready_pin;
      rdy2_r <= rdy1_r;
      lck1_r <= pll_lock_pin;
      lck2_r <= lck1_r;
      fl1_r <= osc_fail_pin;
      fl2_r <= fl1_r;
      fl3_r <= fl2_r;
    end
  end

  // ahb address phase capture
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_r <= 1'b0;
      ap_rd_r <= 1'b0;
      ap_addr_r <= 8'h00;
    end else if (hready) begin
      ap_wr_r <= hsel && htrans[1] && hwrite && hsize == 3'h2;
      ap_rd_r <= hsel && htrans[1] && !hwrite;
      ap_addr_r <= haddr;
    end
  end

  // read mux, data registered one cycle after address phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      case (haddr)
        `CSW_ADDR_CTRL: hrdata <= {17'h00000, current_osc_status_r, 1'b0, new_osc_select_r, 2'h0, lock_r, 1'b0, cf_r, 1'b0,
                                   lpkeep_r, osc_switch_enable_r};
        `CSW_ADDR_UNLOCK: hrdata <= {30'h00000000, key_r};
        `CSW_ADDR_PWR: hrdata <= {29'h00000000, pst_r};
        `CSW_ADDR_STAT: hrdata <= {21'h000000, st_r, sys_clk_sel, 3'h0};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  // unlock key tracking
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      key_r <= 2'h0;
    end else if (wr_unlock) begin
      if (key_r == 2'h0 && (hwdata[7:0] == `CSW_KEY1 || hwdata[7:0] == `CSW_KEY3))
        key_r <= 2'h1;
      else if (key_r == 2'h1 && (hwdata[7:0] == `CSW_KEY2 || hwdata[7:0] == `CSW_KEY4))
        key_r <= 2'h2;
      else
        key_r <= 2'h0;
    end else if (ap_wr_r || ap_rd_r) begin
      key_r <= 2'h0; // [RL23]
    end
  end

  // switch engine and control register
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= S_IDLE;
      new_osc_select_r <= 3'h0;
      current_osc_status_r <= 3'h0;
      old_r <= 3'h0;
      osc_switch_enable_r <= 1'b0;
      cf_r <= 1'b0;
      lock_r <= 1'b0;
      lpkeep_r <= 1'b0;
      osc_enable <= 6'h00;
      sys_clk_sel <= 3'h0;
      primary_submode <= 2'h0;
      clock_fail_trap <= 1'b0;
      init_r <= 1'b0;
      hold_r <= 2'h0;
    end else begin
      init_r <= 1'b1;
      clock_fail_trap <= 1'b0;
      primary_submode <= primary_submode_cfg; // [RL13]
      if (lck2_r)
        lock_r <= 1'b1;
      if (wr_ctrl && unlocked) begin // [RL23] [RL4]
        new_osc_select_r <= hwdata[`CSW_NEW_OSC_SELECT_LSB+2:`CSW_NEW_OSC_SELECT_LSB];
        lpkeep_r <= hwdata[`CSW_LPKEEP_BIT];
        if (sw_en && hwdata[`CSW_OSC_SWITCH_ENABLE_BIT])
          osc_switch_enable_r <= 1'b1; // [RL3]
      end
      if (!init_r) begin
        // pick up the configured source once, whatever the switch setting
        current_osc_status_r <= initial_osc_select_cfg;
        new_osc_select_r <= initial_osc_select_cfg;
        sys_clk_sel <= initial_osc_select_cfg;
        osc_enable <= 6'h01 << initial_osc_select_cfg;
        st_r <= S_IDLE;
      end else if (!sw_en) begin
        current_osc_status_r <= initial_osc_select_cfg; // [RL2]
        sys_clk_sel <= initial_osc_select_cfg;
        osc_switch_enable_r <= 1'b0; // [RL3]
        osc_enable <= 6'h01 << initial_osc_select_cfg;
        if (watchdog_en)
          osc_enable[`CSW_SRC_LOW_POWER_RC_OSC] <= 1'b1;
        st_r <= S_IDLE;
        if (sleeping)
          osc_enable <= {watchdog_en, 5'h00}; // [RL18] [RL19]
      end else if (fail_rise && st_r == S_IDLE && !sleeping) begin
        // fallback keeps pll when active source used it
        clock_fail_trap <= 1'b1; // [RL15]
        cf_r <= 1'b1;
        if (current_osc_status_r == `CSW_SRC_PRIPLL || current_osc_status_r == `CSW_SRC_FAST_RC_WITH_MULTIPLIER) begin
          current_osc_status_r <= `CSW_SRC_FAST_RC_WITH_MULTIPLIER; // [RL16]
          sys_clk_sel <= `CSW_SRC_FAST_RC_WITH_MULTIPLIER;
          osc_enable[`CSW_SRC_FAST_RC_WITH_MULTIPLIER] <= 1'b1;
        end else begin
          current_osc_status_r <= `CSW_SRC_FRC; // [RL15]
          sys_clk_sel <= `CSW_SRC_FRC;
          osc_enable[`CSW_SRC_FRC] <= 1'b1;
        end
        osc_enable[`CSW_SRC_LOW_POWER_RC_OSC] <= 1'b1; // [RL14]
      end else if (sleeping) begin
        // stopped source comes back on wake through the keep lines below
        osc_enable <= {watchdog_en, 5'h00}; // [RL18] [RL19]
        // lp crystal keeps running while its keep bit is set
        if (lpkeep_r)
          osc_enable[`CSW_SRC_LP] <= 1'b1; // [RL10]
      end else begin
        osc_enable[`CSW_SRC_LOW_POWER_RC_OSC] <= low_power_rc_osc_keep | (sys_clk_sel == `CSW_SRC_LOW_POWER_RC_OSC); // [RL14]
        osc_enable[sys_clk_sel] <= 1'b1; // [RL21]
        if (st_r == S_WAIT || st_r == S_SETTLE)
          osc_enable[new_osc_select_r] <= 1'b1;
        case (st_r)
          S_IDLE: begin
            if (osc_switch_enable_r) begin
              // unused source codes abort like a redundant switch
              if (new_osc_select_r == current_osc_status_r || new_osc_select_r > `CSW_SRC_LOW_POWER_RC_OSC)
                osc_switch_enable_r <= 1'b0; // [RL5]
              else
                st_r <= S_START;
            end
          end
          S_START: begin
            lock_r <= 1'b0; // [RL6]
            cf_r <= 1'b0;
            old_r <= current_osc_status_r;
            osc_enable[new_osc_select_r] <= 1'b1; // [RL7]
            hold_r <= 2'h3;
            st_r <= S_WAIT;
          end
          S_WAIT: begin
            // synced ready still shows the old source for two edges
            if (hold_r != 2'h0)
              hold_r <= hold_r - 2'h1;
            else if (is_pll ? lck2_r : rdy2_r) // [RL7]
              st_r <= S_SETTLE;
          end
          S_SETTLE: begin
            if (settle_done) // [RL8]
              st_r <= S_DONE;
          end
          S_DONE: begin
            sys_clk_sel <= new_osc_select_r;
            current_osc_status_r <= new_osc_select_r; // [RL9]
            osc_switch_enable_r <= 1'b0;
            if (!(old_r == `CSW_SRC_LOW_POWER_RC_OSC && low_power_rc_osc_keep) && !(old_r == `CSW_SRC_LP && lpkeep_r))
              osc_enable[old_r] <= 1'b0; // [RL10]
            st_r <= S_IDLE;
          end
          default: st_r <= S_IDLE;
        endcase
      end
    end
  end

  // power-save modes; core runs during switching
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pst_r <= P_RUN;
      cpu_clk_en <= 1'b1; // [RL11]
      periph_clk_en <= 1'b1;
      wdt_clear <= 1'b0;
      sleeping <= 1'b0;
      idling <= 1'b0;
      wake_cnt_r <= 3'h0;
    end else begin
      wdt_clear <= 1'b0;
      case (pst_r)
        P_RUN: begin
          if (wake_cnt_r != 3'h0) begin
            wake_cnt_r <= wake_cnt_r - 3'h1;
            if (wake_cnt_r == 3'h1)
              cpu_clk_en <= 1'b1; // [RL22]
          end else if (wr_pwr && hwdata[7:0] == `CSW_PS_SLEEP) begin
            wdt_clear <= watchdog_en; // [RL19]
            cpu_clk_en <= 1'b0; // [RL17]
            periph_clk_en <= 1'b0; // [RL18]
            sleeping <= 1'b1;
            pst_r <= P_SLEEP;
          end else if (wr_pwr && hwdata[7:0] == `CSW_PS_IDLE) begin
            wdt_clear <= 1'b1;
            cpu_clk_en <= 1'b0; // [RL17]
            idling <= 1'b1;
            pst_r <= P_IDLE;
          end
        end
        P_SLEEP: begin
          if (wake_irq || wdt_timeout) begin // [RL20]
            cpu_clk_en <= 1'b1; // [RL21]
            periph_clk_en <= 1'b1;
            sleeping <= 1'b0;
            pst_r <= P_RUN;
          end
        end
        P_IDLE: begin
          if (wake_irq || wdt_timeout) begin // [RL20]
            idling <= 1'b0;
            wake_cnt_r <= `CSW_IDLE_WAKE_CYC; // [RL22]
            pst_r <= P_RUN;
          end
        end
        default: pst_r <= P_RUN;
      endcase
    end
  end
endmodule // csw_clock_switch

// [logic/csw_defs.vh]
`ifndef CSW_DEFS_VH
`define CSW_DEFS_VH
// register byte addresses
`define CSW_ADDR_CTRL 8'h00
`define CSW_ADDR_UNLOCK 8'h04
`define CSW_ADDR_PWR 8'h08
`define CSW_ADDR_STAT 8'h0C
// unlock keys, two consecutive writes to the unlock register
`define CSW_KEY1 8'h46
`define CSW_KEY2 8'h57
`define CSW_KEY3 8'h9A
`define CSW_KEY4 8'hB5
// control register field positions
`define CSW_OSC_SWITCH_ENABLE_BIT 0
`define CSW_CF_BIT 3
`define CSW_LOCK_BIT 5
`define CSW_LPKEEP_BIT 1
`define CSW_NEW_OSC_SELECT_LSB 8
`define CSW_CURRENT_OSC_STATUS_LSB 12
// oscillator source codes
`define CSW_SRC_FRC 3'h0
`define CSW_SRC_FAST_RC_WITH_MULTIPLIER 3'h1
`define CSW_SRC_PRI 3'h2
`define CSW_SRC_PRIPLL 3'h3
`define CSW_SRC_LP 3'h4
`define CSW_SRC_LOW_POWER_RC_OSC 3'h5
// power-save operands
`define CSW_PS_SLEEP 8'h00
`define CSW_PS_IDLE 8'h01
// timing
`define CSW_SETTLE_CYC 4'hA
`define CSW_IDLE_WAKE_CYC 3'h3
`endif

// [logic/csw_new_clk_counter.v]
`include "csw_defs.vh"
module csw_new_clk_counter #(
  parameter CNT = 10
) (
  input wire hclk, // system clock
  input wire hresetn, // async reset, active low
  input wire start, // restart count
  input wire new_clk_pin, // target oscillator clock, async
  output reg done // count reached
);
  reg s1_r;
  reg s2_r;
  reg s3_r;
  reg [3:0] cnt_r;
  reg [3:0] cnt_nxt;
  wire rise;
  assign rise = s2_r & ~s3_r;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= new_clk_pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  always @* begin
    cnt_nxt = cnt_r;
    if (start)
      cnt_nxt = 4'h0;
    else if (rise && cnt_r != CNT[3:0])
      cnt_nxt = cnt_r + 4'h1;
  end
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= 4'h0;
      done <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      done <= (cnt_nxt == CNT[3:0]) && !start;
    end
  end
endmodule // csw_new_clk_counter

// [testbench/csw_chk.sv]
module csw_chk (
  input wire hclk, // clock
  input wire hresetn, // reset, active low
  input wire hreadyout, // ready
  input wire hresp, // response
  input wire switch_monitor_cfg, // cfg
  input wire [2:0] initial_osc_select_cfg, // reset source
  input wire watchdog_en, // watchdog on
  input wire wake_irq, // wake
  input wire wdt_timeout, // timeout
  input wire [5:0] osc_enable, // sources on
  input wire [2:0] sys_clk_sel, // source
  input wire clock_fail_trap, // trap
  input wire cpu_clk_en, // core gate
  input wire periph_clk_en, // periph gate
  input wire wdt_clear, // clear pulse
  input wire sleeping, // sleep
  input wire idling // idle
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_wake;
    wake_irq || wdt_timeout;
  endsequence
  sequence s_core_back;
    !cpu_clk_en ##[1:4] cpu_clk_en;
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  a_cfg_fixed: assert property (switch_monitor_cfg && $past(hresetn) |-> sys_clk_sel == initial_osc_select_cfg)
    else $error("source differs from initial config");
  a_trap_cfg: assert property (clock_fail_trap |-> !switch_monitor_cfg)
    else $error("trap while monitor disabled");
  a_trap_fast_rc: assert property (clock_fail_trap |-> ##[0:2] (sys_clk_sel < 3'h2))
    else $error("no fallback to fast rc");
  a_trap_pulse: assert property (clock_fail_trap |=> !clock_fail_trap)
    else $error("trap longer than one cycle");
  a_sleep_gates: assert property (sleeping |-> !cpu_clk_en && !periph_clk_en && !clock_fail_trap)
    else $error("clock running in sleep");
  a_idle_gates: assert property (idling |-> !cpu_clk_en && periph_clk_en)
    else $error("idle gating wrong");
  a_sleep_wdt: assert property ($rose(sleeping) && watchdog_en |-> wdt_clear)
    else $error("watchdog not cleared on sleep");
  a_sleep_low_power_rc_osc: assert property (sleeping && watchdog_en |-> osc_enable[5])
    else $error("low-power rc off in sleep");
  a_sleep_wake: assert property (sleeping ##0 s_wake |=> !sleeping && cpu_clk_en)
    else $error("no wake from sleep");
  a_sleep_stop: assert property ($past(sleeping) && sleeping |-> osc_enable[3:0] == 4'h0)
    else $error("source running in sleep");
  a_sleep_src: assert property (sleeping |=> $stable(sys_clk_sel))
    else $error("source changed in sleep");
  a_idle_wake: assert property ($fell(idling) |-> s_core_back)
    else $error("core clock late after idle");
endmodule // csw_chk
bind csw_clock_switch csw_chk u_chk (.hclk, .hresetn, .hreadyout, .hresp, .switch_monitor_cfg,
  .initial_osc_select_cfg, .watchdog_en, .wake_irq, .wdt_timeout, .osc_enable, .sys_clk_sel,
  .clock_fail_trap, .cpu_clk_en, .periph_clk_en, .wdt_clear, .sleeping, .idling);

// [testbench/csw_osc_model.sv]
module csw_osc_model (
  input wire [5:0] osc_enable, // sources on
  input wire slow, // long start-up
  input wire fail_req, // force failure
  output logic new_clk_pin, // source clock
  output logic osc_ready_pin, // start-up done
  output logic pll_lock_pin, // lock
  output logic osc_fail_pin // failure
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  logic [5:0] en_q = 6'h00;
  initial new_clk_pin = 1'b0;
  // stands still while no source is on
  always #17 if (osc_enable != 6'h00) new_clk_pin = ~new_clk_pin;
  always @(posedge new_clk_pin) begin
    en_q <= osc_enable;
    cnt <= (osc_enable != en_q) ? 0 : (cnt < 99 ? cnt + 1 : cnt);
  end
  assign osc_ready_pin = (osc_enable == en_q) && (cnt >= (slow ? 40 : 3));
  assign pll_lock_pin = osc_ready_pin;
  assign osc_fail_pin = fail_req;
endmodule // csw_osc_model

// [testbench/tb.sv]
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, switch_monitor_cfg = 1, watchdog_en = 0;
  logic wake_irq = 0, wdt_timeout = 0, slow = 0, fail = 0;
  logic [7:0] haddr = 0;
  logic [1:0] htrans = 0, primary_submode_cfg = 2'h1;
  logic [2:0] hsize = 3'h2, initial_osc_select_cfg = 3'h2;
  logic [31:0] hwdata = 0, q;
  wire hready, hreadyout, hresp, osc_ready_pin, pll_lock_pin, new_clk_pin, osc_fail_pin;
  wire clock_fail_trap, cpu_clk_en, periph_clk_en, wdt_clear, sleeping, idling;
  wire [31:0] hrdata;
  wire [5:0] osc_enable;
  wire [2:0] sys_clk_sel;
  wire [1:0] primary_submode;
  int err_count = 0, cmp_count = 0, cyc = 0, n;
  assign hready = hreadyout;
  always #10 hclk = ~hclk;
  csw_clock_switch uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .switch_monitor_cfg, .initial_osc_select_cfg, .primary_submode_cfg,
    .watchdog_en, .osc_ready_pin, .pll_lock_pin, .new_clk_pin, .osc_fail_pin, .wake_irq, .wdt_timeout,
    .osc_enable, .sys_clk_sel, .primary_submode, .clock_fail_trap, .cpu_clk_en, .periph_clk_en,
    .wdt_clear, .sleeping, .idling);
  csw_osc_model u_osc (.osc_enable, .slow, .fail_req(fail), .new_clk_pin, .osc_ready_pin,
    .pll_lock_pin, .osc_fail_pin);
  task results;
    $display("mismatches %0d comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      results;
    end
  end
  task chk(input string s, input logic [2:0] e, input logic [2:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", s, e, g);
    end
  endtask
  task wt;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
  endtask
  task bus(input w, input [7:0] a, input [31:0] d);
    hsel <= 1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    wt;
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    wt;
    q = hrdata;
  endtask
  task ctl(input [31:0] d);
    bus(1, 8'h04, 32'h46);
    bus(1, 8'h04, 32'h57);
    bus(1, 8'h00, d);
  endtask
  task rst(input c, input [2:0] s);
    hresetn <= 0;
    switch_monitor_cfg <= c;
    initial_osc_select_cfg <= s;
    repeat (10) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk);
  endtask
  task sw(input [2:0] t, input k);
    ctl({21'h0, t, 6'h0, k, 1'b1});
    q = 32'h1;
    for (int i = 0; i < 300 && q[0] !== 1'b0; i++) bus(0, 8'h00, 32'h0);
    chk("enable", 3'h0, {2'h0, q[0]});
    chk("status", t, q[14:12]);
    chk("source", t, sys_clk_sel);
  endtask
  task fl(input [2:0] e);
    fail <= 1;
    repeat (6) @(posedge hclk);
    fail <= 0;
    bus(0, 8'h00, 32'h0);
    chk("fallback", e, sys_clk_sel);
    chk("fail flag", 3'h1, {2'h0, q[3]});
  endtask
  task t_off;
    rst(1, 3'h2);
    ctl(32'h0001);
    bus(0, 8'h00, 32'h0);
    chk("status", 3'h2, q[14:12]);
    chk("enable", 3'h0, {2'h0, q[0]});
    chk("source", 3'h2, sys_clk_sel);
    chk("submode", 3'h1, {1'h0, primary_submode});
  endtask
  task t_lock;
    rst(0, 3'h0);
    bus(1, 8'h00, 32'h0301);
    bus(0, 8'h00, 32'h0);
    chk("no unlock", 3'h0, q[10:8]);
    bus(1, 8'h04, 32'h46);
    bus(1, 8'h04, 32'h57);
    bus(0, 8'h0C, 32'h0);
    bus(1, 8'h00, 32'h0301);
    bus(1, 8'h20, 32'hFFFF);
    bus(0, 8'h00, 32'h0);
    chk("broken unlock", 3'h0, q[10:8]);
    sw(3'h0, 0);
  endtask
  task t_sw;
    sw(3'h2, 0);
    chk("old off", 3'h0, {2'h0, osc_enable[0]});
    fl(3'h0);
    slow <= 1;
    sw(3'h3, 0);
    chk("flag cleared", 3'h0, {2'h0, q[3]});
    chk("lock", 3'h1, {2'h0, q[5]});
    slow <= 0;
    fl(3'h1);
    sw(3'h0, 0);
    sw(3'h4, 1);
    sw(3'h5, 1);
    chk("crystal kept", 3'h1, {2'h0, osc_enable[4]});
    watchdog_en <= 1;
    sw(3'h0, 1);
    chk("rc kept", 3'h1, {2'h0, osc_enable[5]});
  endtask
  task t_pwr;
    bus(1, 8'h08, 32'h0);
    fail <= 1;
    repeat (4) @(posedge hclk);
    fail <= 0;
    @(negedge hclk);
    chk("sleep", 3'h1, {2'h0, sleeping});
    chk("source off", 3'h0, {2'h0, osc_enable[0]});
    @(posedge hclk);
    wake_irq <= 1;
    @(posedge hclk);
    wake_irq <= 0;
    @(negedge hclk);
    chk("awake", 3'h0, {2'h0, sleeping});
    chk("same source", 3'h0, sys_clk_sel);
    @(posedge hclk);
    bus(1, 8'h08, 32'h1);
    bus(0, 8'h08, 32'h0);
    chk("power state", 3'h4, q[2:0]);
    chk("source back", 3'h1, {2'h0, osc_enable[0]});
    wdt_timeout <= 1;
    @(posedge hclk);
    wdt_timeout <= 0;
    n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while (cpu_clk_en !== 1'b1 && n < 20);
    chk("idle wake", 3'h1, {2'h0, n >= 3 && n <= 5});
    @(posedge hclk);
  endtask
  initial begin
    t_off;
    t_lock;
    t_sw;
    t_pwr;
    results;
  end
endmodule // tb
